//--- adcc_defs.svh
// constants for the converter control block: positions, reset values, timing
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH
`define ADCC_RES_BITS       10
`define ADCC_NUM_EXT_CH     6
`define ADCC_CONV_PERIODS   13
`define ADCC_CH_BIAS        4'hF
`define ADCC_HI_CKSEL_MSB   7
`define ADCC_HI_CKSEL_LSB   6
`define ADCC_HI_BYTE_BIT    5
`define ADCC_CH_RST         4'h0
`define ADCC_CKSEL_RST      2'h0
`define ADCC_BYTE_RST       1'b0
`define ADCC_DONE_RST       1'b0
`define ADCC_IRQ_RST        1'b0
`define ADCC_CLK_PERIOD_NS  50
`define ADCC_MIN_CONV_CLK_NS 1000
`define ADCC_MIN_CONV_CLK_CYC ((`ADCC_MIN_CONV_CLK_NS + `ADCC_CLK_PERIOD_NS - 1) / `ADCC_CLK_PERIOD_NS)
`endif

//--- adcc_pkg.sv
// types shared by the converter control block
package adcc_pkg;
	// successive approximation sequencer states, one-hot
	typedef enum logic [3:0] {
		ADCC_IDLE   = 4'h1,
		ADCC_SAMPLE = 4'h2,
		ADCC_DECIDE = 4'h4,
		ADCC_FINISH = 4'h8
	} adcc_state_t;
endpackage

//--- adcc_sar_core.sv
// successive approximation sequencer stepped by converter clock ticks
`timescale 1ns/1ps
`default_nettype none
module adcc_sar_core #(
	parameter int RES   = 10,
	parameter int STEPS = 13
) (
	input  wire logic           clk_sys,
	input  wire logic           rst_b,
	input  wire logic           start,
	input  wire logic           tick,
	input  wire logic           comp_hi,
	output logic                busy,
	output logic                sample_hold,
	output logic [RES-1:0]      trial_code,
	output logic [RES-1:0]      result,
	output logic                done
);
	localparam int SW = $clog2(STEPS);

	// one sample step, one step per bit, the rest settles
	if (STEPS < RES + 2)
	begin : g_chk
		$error("adcc_sar_core: STEPS too small for RES");
	end

	adcc_pkg::adcc_state_t state_r, state_nxt;  // sequencer state
	logic [SW-1:0]  step_r, step_nxt;           // converter periods used
	logic [RES-1:0] code_r, code_nxt;           // trial code under test
	logic [RES-1:0] mask_r, mask_nxt;           // bit being decided
	logic [RES-1:0] result_r, result_nxt;       // last finished code
	logic           done_r, done_nxt;           // completion pulse
	logic [RES-1:0] kept;                       // code after current decision

	// next state: one converter period per step
	always_comb
	begin
		state_nxt  = state_r;
		step_nxt   = step_r;
		code_nxt   = code_r;
		mask_nxt   = mask_r;
		result_nxt = result_r;
		done_nxt   = 1'b0;
		kept       = comp_hi ? code_r : (code_r & ~mask_r);
		if (start)
		begin
			// a new start aborts any conversion under way
			state_nxt = adcc_pkg::ADCC_SAMPLE;
			step_nxt  = '0;
			code_nxt  = '0;
			mask_nxt  = {1'b1, {(RES-1){1'b0}}};
		end
		else if (tick)
		begin
			case (state_r)
				adcc_pkg::ADCC_SAMPLE:
				begin
					state_nxt = adcc_pkg::ADCC_DECIDE;
					step_nxt  = step_r + SW'(1);
					code_nxt  = mask_r;
				end
				adcc_pkg::ADCC_DECIDE:
				begin
					// keep the trial bit only when input is at or above it
					step_nxt = step_r + SW'(1);
					mask_nxt = mask_r >> 1;
					code_nxt = kept | (mask_r >> 1);
					if (mask_r[0])
					begin
						state_nxt = adcc_pkg::ADCC_FINISH;
					end
				end
				adcc_pkg::ADCC_FINISH:
				begin
					if (step_r == SW'(STEPS - 1))
					begin
						// thirteenth period ends the conversion
						state_nxt  = adcc_pkg::ADCC_IDLE;
						result_nxt = code_r;
						done_nxt   = 1'b1;
					end
					else
					begin
						step_nxt = step_r + SW'(1);
					end
				end
				adcc_pkg::ADCC_IDLE:
				begin
					state_nxt = adcc_pkg::ADCC_IDLE;
				end
				default:
				begin
					state_nxt = adcc_pkg::ADCC_IDLE;
				end
			endcase
		end
	end

	// sequencer registers
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_r  <= adcc_pkg::ADCC_IDLE;
			step_r   <= '0;
			code_r   <= '0;
			mask_r   <= '0;
			result_r <= '0;
			done_r   <= 1'b0;
		end
		else
		begin
			state_r  <= state_nxt;
			step_r   <= step_nxt;
			code_r   <= code_nxt;
			mask_r   <= mask_nxt;
			result_r <= result_nxt;
			done_r   <= done_nxt;
		end
	end

	assign busy        = (state_r != adcc_pkg::ADCC_IDLE);
	assign sample_hold = (state_r == adcc_pkg::ADCC_SAMPLE);
	assign trial_code  = code_r;
	assign result      = result_r;
	assign done        = done_r;
endmodule
`default_nettype wire

//--- adcc_conversion_control.sv
// control logic of the ten-bit successive approximation converter
//
// Summary of operation
// - convert selected input to ten bits by approximation
// - six external inputs muxed into one sample-hold
// - channel all ones selects internal bias reference
// - start bit begins conversion, clears after one cycle
// - normal mode: ten bits across high and low
// - byte mode: eight-bit result in low register
// - completion loads result, sets done and interrupt
// - done reads zero while converting, set when finished
// - conversion lasts exactly thirteen converter clock periods
// - high register top two bits select converter clock
`include "adcc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module adcc_conversion_control #(
	parameter int DIV0 = `ADCC_MIN_CONV_CLK_CYC,
	parameter int DIV1 = 2 * `ADCC_MIN_CONV_CLK_CYC,
	parameter int DIV2 = 4 * `ADCC_MIN_CONV_CLK_CYC,
	parameter int DIV3 = 8 * `ADCC_MIN_CONV_CLK_CYC
) (
	input  wire logic                      clk_sys,
	input  wire logic                      rst_b,
	input  wire logic                      ctrl_wr,
	input  wire logic                      ctrl_wr_start,
	input  wire logic [3:0]                ctrl_wr_channel,
	input  wire logic                      high_wr,
	input  wire logic [1:0]                high_wr_clk_sel,
	input  wire logic                      high_wr_byte_mode,
	input  wire logic                      irq_clear,
	input  wire logic                      comp_hi,
	output logic                           conversion_start_bit,
	output logic [3:0]                     channel_select,
	output logic                           conversion_done_status,
	output logic                           conversion_irq_flag,
	output logic [7:0]                     result_high_reg,
	output logic [7:0]                     result_low_reg,
	output logic [`ADCC_NUM_EXT_CH-1:0]    analog_input_sel,
	output logic                           bias_ref_sel,
	output logic                           sample_hold,
	output logic [`ADCC_RES_BITS-1:0]      dac_code,
	output logic                           converter_clock
);
	localparam int RES = `ADCC_RES_BITS;
	localparam int PW  = 16;

	// dividers must give a real period and fit the prescaler
	if (DIV0 < 2 || DIV1 < 2 || DIV2 < 2 || DIV3 < 2 ||
	    DIV0 >= 65536 || DIV1 >= 65536 || DIV2 >= 65536 || DIV3 >= 65536)
	begin : g_chk
		$error("adcc_conversion_control: divider out of range");
	end

	logic           start_r, start_nxt;         // self-clearing start bit
	logic [3:0]     chan_r, chan_nxt;           // input channel field
	logic [1:0]     cksel_r, cksel_nxt;         // converter clock select
	logic           byte_r, byte_nxt;           // eight-bit result mode
	logic [PW-1:0]  pcnt_r, pcnt_nxt;           // prescaler count
	logic           tick_r, tick_nxt;           // end of one converter period
	logic           done_st_r, done_st_nxt;     // conversion finished status
	logic           irq_r, irq_nxt;             // conversion interrupt flag
	logic [7:0]     hi_r, hi_nxt;               // high result register image
	logic [7:0]     lo_r, lo_nxt;               // low result register image
	logic [PW-1:0]  div_sel;                    // selected division ratio
	logic           busy;                       // sequencer is converting
	logic           conv_done;                  // completion pulse from sequencer
	logic [RES-1:0] conv_result;                // held conversion code

	// control field: start bit lives one cycle, channel holds
	always_comb
	begin
		start_nxt = 1'b0; // hardware clears it after one cycle
		chan_nxt  = chan_r;
		if (ctrl_wr)
		begin
			start_nxt = ctrl_wr_start; // writing one begins a conversion
			chan_nxt  = ctrl_wr_channel;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			start_r <= 1'b0;
			chan_r  <= `ADCC_CH_RST;
		end
		else
		begin
			start_r <= start_nxt;
			chan_r  <= chan_nxt;
		end
	end

	// configuration bits held in the high result register
	always_comb
	begin
		cksel_nxt = cksel_r;
		byte_nxt  = byte_r;
		if (high_wr)
		begin
			cksel_nxt = high_wr_clk_sel;
			byte_nxt  = high_wr_byte_mode;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cksel_r <= `ADCC_CKSEL_RST;
			byte_r  <= `ADCC_BYTE_RST;
		end
		else
		begin
			cksel_r <= cksel_nxt;
			byte_r  <= byte_nxt;
		end
	end

	// input mux: one enable per external pin, bias on all ones
	genvar gi;
	generate
		for (gi = 0; gi < `ADCC_NUM_EXT_CH; gi++)
		begin : g_mux
			assign analog_input_sel[gi] = (chan_r == 4'(gi));
		end
	endgenerate
	// unused codes select nothing, so no pin is loaded by accident
	assign bias_ref_sel = (chan_r == `ADCC_CH_BIAS);

	// prescaler ratio chosen by the clock select field
	always_comb
	begin
		case (cksel_r)
			2'h0:    div_sel = PW'(DIV0);
			2'h1:    div_sel = PW'(DIV1);
			2'h2:    div_sel = PW'(DIV2);
			2'h3:    div_sel = PW'(DIV3);
			default: div_sel = PW'(DIV0);
		endcase
	end

	// prescaler restarts with each start so the first period is whole
	always_comb
	begin
		pcnt_nxt = pcnt_r + PW'(1);
		tick_nxt = 1'b0;
		if (start_r)
		begin
			pcnt_nxt = '0; // aligns periods to the start request
		end
		else if (pcnt_r >= div_sel - PW'(1))
		begin
			// >= also recovers when the ratio shrinks mid count
			pcnt_nxt = '0;
			tick_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pcnt_r <= '0;
			tick_r <= 1'b0;
		end
		else
		begin
			pcnt_r <= pcnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	// approximation sequencer on the sample-hold output
	adcc_sar_core #(
		.RES   (RES),
		.STEPS (`ADCC_CONV_PERIODS)
	) u_sar (
		.clk_sys     (clk_sys),
		.rst_b       (rst_b),
		.start       (start_r),
		.tick        (tick_r && !start_r),
		.comp_hi     (comp_hi),
		.busy        (busy),
		.sample_hold (sample_hold),
		.trial_code  (dac_code),
		.result      (conv_result),
		.done        (conv_done)
	);

	// status: done clears on start, interrupt set beats clear
	always_comb
	begin
		done_st_nxt = done_st_r;
		irq_nxt     = irq_r;
		if (conv_done)
		begin
			done_st_nxt = 1'b1; // set together with the result load
		end
		if (start_r)
		begin
			done_st_nxt = 1'b0; // a new conversion is in progress
		end
		if (irq_clear)
		begin
			irq_nxt = 1'b0;
		end
		if (conv_done)
		begin
			irq_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			done_st_r <= `ADCC_DONE_RST;
			irq_r     <= `ADCC_IRQ_RST;
		end
		else
		begin
			done_st_r <= done_st_nxt;
			irq_r     <= irq_nxt;
		end
	end

	// result images; the code only changes on completion
	always_comb
	begin
		hi_nxt = 8'h00;
		hi_nxt[`ADCC_HI_CKSEL_MSB:`ADCC_HI_CKSEL_LSB] = cksel_nxt;
		hi_nxt[`ADCC_HI_BYTE_BIT] = byte_nxt;
		if (byte_nxt)
		begin
			lo_nxt = conv_result[RES-1:RES-8]; // whole byte in low register
		end
		else
		begin
			hi_nxt[1:0] = conv_result[RES-1:8];
			lo_nxt      = conv_result[7:0];
		end
	end

	// images load every cycle: the code moves on the done pulse, the layout on high register writes
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			hi_r <= 8'h00;
			lo_r <= 8'h00;
		end
		else
		begin
			hi_r <= hi_nxt;
			lo_r <= lo_nxt;
		end
	end

	assign conversion_start_bit   = start_r;
	assign channel_select         = chan_r;
	assign conversion_done_status = done_st_r && !busy;
	assign conversion_irq_flag    = irq_r;
	assign result_high_reg        = hi_r;
	assign result_low_reg         = lo_r;
	assign converter_clock        = tick_r;
endmodule
`default_nettype wire

//--- adcc_analog_model.sv
// behavioural analog side: pins, bias source, hold capacitor and comparator
`timescale 1ns/1ps
`default_nettype none
module adcc_analog_model (
	input  wire logic        clk_sys,
	input  wire logic [59:0] pin_levels,
	input  wire logic [9:0]  bias_level,
	input  wire logic [5:0]  analog_input_sel,
	input  wire logic        bias_ref_sel,
	input  wire logic        sample_hold,
	input  wire logic [9:0]  dac_code,
	output logic             comp_hi
);
	logic [9:0] held;           // frozen level, unknown until the first sample
	logic [9:0] live;           // mux output
	// unselected mux reads as ground, never as the last pin
	always_comb
	begin
		live = 10'h000;
		for (int i = 0; i < 6; i++)
			if (analog_input_sel[i])
				live = pin_levels[i*10 +: 10];
		if (bias_ref_sel)
			live = bias_level;
	end
	// ideal hold: tracks while sampling, frozen afterwards
	always_ff @(posedge clk_sys)
		if (sample_hold)
			held <= live;
	// pins are only driven here, never read as digital mid conversion
	assign comp_hi = held >= dac_code;
endmodule
`default_nettype wire

//--- adcc_conversion_control_chk.sv
// assertion checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcc_conversion_control_chk (
	input wire logic       clk_sys,
	input wire logic       rst_b,
	input wire logic       ctrl_wr,
	input wire logic       ctrl_wr_start,
	input wire logic [3:0] ctrl_wr_channel,
	input wire logic       high_wr,
	input wire logic       irq_clear,
	input wire logic       conversion_start_bit,
	input wire logic [3:0] channel_select,
	input wire logic       conversion_done_status,
	input wire logic       conversion_irq_flag,
	input wire logic [7:0] result_low_reg,
	input wire logic [5:0] analog_input_sel,
	input wire logic       bias_ref_sel,
	input wire logic       sample_hold,
	input wire logic       converter_clock
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	logic [4:0] tick_cnt_r;  // converter periods since the last start
	logic [4:0] tick_cnt_nxt;
	// saturates so a stale count never wraps back to thirteen
	always_comb
	begin
		tick_cnt_nxt = tick_cnt_r;
		if (conversion_start_bit)
			tick_cnt_nxt = 5'h00;
		else if (converter_clock && tick_cnt_r != 5'h1F)
			tick_cnt_nxt = tick_cnt_r + 5'h01;
	end
	always_ff @(posedge clk_sys or negedge rst_b)
		if (!rst_b)
			tick_cnt_r <= 5'h1F;
		else
			tick_cnt_r <= tick_cnt_nxt;
	sequence s_start;
		ctrl_wr && ctrl_wr_start;
	endsequence
	sequence s_conv_open;
		conversion_start_bit ##1 (sample_hold && !conversion_done_status);
	endsequence
	a_start_pulse: assert property (s_start ##1 !(ctrl_wr && ctrl_wr_start)
		|=> !conversion_start_bit) else $error("start bit stuck high");
	a_start_opens: assert property (s_start |=> s_conv_open)
		else $error("start did not open a conversion");
	a_done_thirteen: assert property ($rose(conversion_done_status)
		|-> tick_cnt_r == 5'h0D) else $error("conversion length wrong");
	a_done_with_irq: assert property ($rose(conversion_done_status)
		|-> conversion_irq_flag) else $error("irq missing at completion");
	a_done_idle: assert property (conversion_start_bit
		|=> !conversion_done_status [*8]) else $error("done high while converting");
	a_result_hold: assert property (!$stable(result_low_reg) && !$past(high_wr)
		|-> $rose(conversion_done_status)) else $error("result changed early");
	a_irq_sticky: assert property (conversion_irq_flag && !irq_clear
		|=> conversion_irq_flag) else $error("irq dropped by itself");
	a_irq_clear: assert property (irq_clear
		|=> !conversion_irq_flag || $rose(conversion_done_status)) else $error("irq not cleared");
	a_pin_select: assert property (channel_select < 4'h6
		|-> analog_input_sel == 6'h01 << channel_select) else $error("pin mux wrong");
	a_bias_select: assert property (bias_ref_sel == (channel_select == 4'hF))
		else $error("bias select wrong");
	a_channel_write: assert property (ctrl_wr
		|=> channel_select == $past(ctrl_wr_channel)) else $error("channel not taken");
endmodule
bind adcc_conversion_control adcc_conversion_control_chk i_chk (.clk_sys, .rst_b, .ctrl_wr,
	.ctrl_wr_start, .ctrl_wr_channel, .high_wr, .irq_clear, .conversion_start_bit,
	.channel_select, .conversion_done_status, .conversion_irq_flag, .result_low_reg,
	.analog_input_sel, .bias_ref_sel, .sample_hold, .converter_clock);
`default_nettype wire

//--- adcc_conversion_control_tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcc_conversion_control_tb_top;
	logic        clk_sys = 1'b0;
	logic        rst_b = 1'b0;
	logic        ctrl_wr = 1'b0;
	logic        ctrl_wr_start = 1'b0;
	logic [3:0]  ctrl_wr_channel = 4'h0;
	logic        high_wr = 1'b0;
	logic [1:0]  high_wr_clk_sel = 2'h0;
	logic        high_wr_byte_mode = 1'b0;
	logic        irq_clear = 1'b0;
	logic        comp_hi;
	logic        conversion_start_bit;
	logic [3:0]  channel_select;
	logic        conversion_done_status;
	logic        conversion_irq_flag;
	logic [7:0]  result_high_reg;
	logic [7:0]  result_low_reg;
	logic [5:0]  analog_input_sel;
	logic        bias_ref_sel;
	logic        sample_hold;
	logic [9:0]  dac_code;
	logic        converter_clock;
	logic [59:0] pin_levels = {10'h1FF, 10'h201, 10'h2AA, 10'h155, 10'h000, 10'h3FF}; // edges
	logic [9:0]  bias_level = 10'h0ED;
	int          err_total = 0;
	int          num_checks = 0;
	int          div_cyc [4] = '{2, 3, 4, 20}; // divider per clock select, as below
	// short dividers keep runs brief; select 3 keeps a full 1 us period
	adcc_conversion_control #(.DIV0(2), .DIV1(3), .DIV2(4), .DIV3(20)) i_dut (.clk_sys, .rst_b,
		.ctrl_wr, .ctrl_wr_start, .ctrl_wr_channel, .high_wr, .high_wr_clk_sel,
		.high_wr_byte_mode, .irq_clear, .comp_hi, .conversion_start_bit, .channel_select,
		.conversion_done_status, .conversion_irq_flag, .result_high_reg, .result_low_reg,
		.analog_input_sel, .bias_ref_sel, .sample_hold, .dac_code, .converter_clock);
	adcc_analog_model i_analog (.clk_sys, .pin_levels, .bias_level, .analog_input_sel,
		.bias_ref_sel, .sample_hold, .dac_code, .comp_hi);
	initial
	begin
		forever #25 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// inputs always move 5 ns after the rising edge
	task automatic step;
		@(posedge clk_sys);
		#5;
	endtask
	task automatic wr_ctrl(input logic [3:0] ch, input logic st);
		ctrl_wr = 1'b1;
		ctrl_wr_start = st;
		ctrl_wr_channel = ch;
		step;
		ctrl_wr = 1'b0;
	endtask
	// one whole conversion, timed from the start write, then irq clear
	task automatic convert(input logic [3:0] ch, input logic [1:0] sel, input logic mode);
		int n;
		logic [9:0] v;
		v = (ch == 4'hF) ? bias_level : pin_levels[ch*10 +: 10];
		high_wr = 1'b1;
		high_wr_clk_sel = sel;
		high_wr_byte_mode = mode;
		step;
		high_wr = 1'b0;
		wr_ctrl(ch, 1'b1);
		chk(conversion_start_bit, 1'b1);
		chk(analog_input_sel, ch < 4'h6 ? 6'h01 << ch : 6'h00);
		chk(bias_ref_sel, ch == 4'hF);
		n = 0;
		// step at least once: the old done status shows until the start lands
		do
		begin
			step;
			n++;
			if (n == 1)
				chk(conversion_start_bit, 1'b0);
			if (n == 1)
				chk(conversion_done_status, 1'b0);
			if (n == div_cyc[sel] + 2)
				chk(dac_code, 10'h200);
		end
		while (conversion_done_status !== 1'b1 && n < 400);
		// thirteen periods plus start, sequencer and register stages
		chk(n, 13 * div_cyc[sel] + 3);
		if (n >= 400)
			tally_and_finish;
		chk(conversion_irq_flag, 1'b1);
		chk(result_low_reg, mode ? v[9:2] : v[7:0]);
		chk({result_high_reg[7:5], result_high_reg[1:0]}, {sel, mode, mode ? 2'h0 : v[9:8]});
		irq_clear = 1'b1;
		step;
		irq_clear = 1'b0;
		chk(conversion_irq_flag, 1'b0);
		chk(conversion_done_status, 1'b1);
	endtask
	task automatic t_reset_values;
		chk({channel_select, analog_input_sel}, 10'h001);
		chk({conversion_done_status, conversion_irq_flag, result_high_reg, result_low_reg}, 0);
	endtask
	task automatic t_all_channels;
		for (int i = 0; i < 7; i++)
			convert(i < 6 ? i[3:0] : 4'hF, i[1:0], i[0]);
	endtask
	// new levels and a channel change must not disturb a finished result
	task automatic t_result_hold;
		bias_level = 10'h13C;
		pin_levels = ~pin_levels;
		wr_ctrl(4'h2, 1'b0);
		repeat (40) step;
		chk(channel_select, 4'h2);
		chk({result_high_reg[1:0], result_low_reg}, 10'h0ED);
		chk(conversion_done_status, 1'b1);
	endtask
	// a second start mid-conversion restarts the full count
	task automatic t_restart;
		wr_ctrl(4'h0, 1'b1);
		repeat (10) step;
		convert(4'h3, 2'h0, 1'b0);
	endtask
	initial
	begin
		repeat (10) @(posedge clk_sys);
		#5;
		rst_b = 1'b1;
		t_reset_values;
		t_all_channels;
		t_result_hold;
		t_restart;
		tally_and_finish;
	end
endmodule
`default_nettype wire
